// ---- hw/aisu_defs.svh ----
// Named constants for the analog input scan and update block
`ifndef AISU_DEFS_SVH
`define AISU_DEFS_SVH

// ==================================================
// Timing
`define AISU_CLK_KHZ     25000
`define AISU_T4_MS       400
`define AISU_T8_MS       710
`define AISU_PEN_MS      220
`define AISU_PWR_MS      3000
`define AISU_MS2CYC(ms)  ((ms) * `AISU_CLK_KHZ)

// ==================================================
// Channels
`define AISU_NCH_MAX     8
`define AISU_LAST4       3'h3
`define AISU_LAST8       3'h7
`define AISU_FIRST_CH    3'h0
`define AISU_HI_CH       4

// ==================================================
// Data codes
`define AISU_ZERO        16'h0000
`define AISU_UNDER_ELEV  16'h0fff
`define AISU_OVER_STD    16'h1000
`define AISU_OVER_ELEV   16'h2000
`define AISU_ELEV_OFS    16'h1000
`define AISU_BCD_ADJ     4'h3
`define AISU_BCD_LIM     4'h5

`endif

// ---- hw/aisu_fmt_if.sv ----
// Carrier between the scan sequencer and the value formatter
`timescale 1ns/1ps
`default_nettype none
interface aisu_fmt_if (
  input wire logic clk,
  input wire logic reset
);
  logic              [11:0] raw;
  logic                     under;
  logic                     over;
  logic                     elevated;
  logic                     bcd;
  aisu_pkg::aisu_word_t     value;
  modport scan (input clk, input reset, output raw, output under, output over,
                output elevated, output bcd, input value);
  modport fmt  (input clk, input reset, input raw, input under, input over,
                input elevated, input bcd, output value);
endinterface
`default_nettype wire

// ---- hw/aisu_format.sv ----
// Value formatter: range codes, coding offset and BCD packing
`timescale 1ns/1ps
`default_nettype none
`include "aisu_defs.svh"
module aisu_format (
  aisu_fmt_if.fmt f
);
  import aisu_pkg::*;

  // ==================================================
  // Binary to BCD, four digits cover the top code 8192
  function automatic aisu_word_t to_bcd(input logic [13:0] b);
    logic [29:0] s;
    s = {16'h0000, b};
    for (int i = 0; i < 14; i++) begin
      for (int j = 0; j < 4; j++) begin
        if (s[14 + 4*j +: 4] >= `AISU_BCD_LIM) begin
          s[14 + 4*j +: 4] = s[14 + 4*j +: 4] + `AISU_BCD_ADJ;
        end
      end
      s = {s[28:0], 1'b0};
    end
    return s[29:14];
  endfunction

  // ==================================================
  // Coding
  aisu_word_t under_code;
  aisu_word_t over_code;
  aisu_word_t valid_code;
  aisu_word_t bin_code;
  assign under_code = f.elevated ? `AISU_UNDER_ELEV : `AISU_ZERO;
  assign over_code  = f.elevated ? `AISU_OVER_ELEV : `AISU_OVER_STD;
  assign valid_code = {4'h0, f.raw} + (f.elevated ? `AISU_ELEV_OFS : `AISU_ZERO);
  // Under range wins when the front end flags both
  assign bin_code   = f.under ? under_code : (f.over ? over_code : valid_code);
  assign f.value    = f.bcd ? to_bcd(bin_code[13:0]) : bin_code;

  // ==================================================
  // Checks
  default clocking cb @(posedge f.clk); endclocking
  default disable iff (f.reset);

  under_code_a: assert property (f.under && !f.bcd |-> f.value == (f.elevated ? 16'h0fff : 16'h0000))
    else $error("under range code wrong");
  over_code_a: assert property (!f.under && f.over && !f.bcd |-> f.value == (f.elevated ? 16'h2000 : 16'h1000))
    else $error("over range code wrong");
  valid_code_a: assert property (!f.under && !f.over && !f.bcd |-> f.value == {4'h0, f.raw} + {3'h0, f.elevated, 12'h000})
    else $error("valid code or elevated offset wrong");
  bcd_code_a: assert property (f.bcd && !f.under && !f.over && !f.elevated && f.raw == 12'hfff |-> f.value == 16'h4095)
    else $error("bcd packing wrong");
  elev_cover_c: cover property (f.elevated && !f.under && !f.over);
endmodule
`default_nettype wire

// ---- hw/aisu_pkg.sv ----
// Types shared by the analog input scan and update block
package aisu_pkg;
  typedef enum logic [1:0] {
    AISU_PWR  = 2'b00,
    AISU_REQ  = 2'b01,
    AISU_WAIT = 2'b11,
    AISU_HOLD = 2'b10
  } aisu_state_e;
  typedef logic [15:0] aisu_word_t;
  typedef logic [2:0]  aisu_chan_t;
endpackage

// ---- hw/aisu_scan.sv ----
// Scan sequencer and channel registers of the analog input module
`timescale 1ns/1ps
`default_nettype none
`include "aisu_defs.svh"
module aisu_scan #(
  parameter int unsigned INT4_CYC = `AISU_MS2CYC(`AISU_T4_MS),
  parameter int unsigned INT8_CYC = `AISU_MS2CYC(`AISU_T8_MS),
  parameter int unsigned PEN_CYC  = `AISU_MS2CYC(`AISU_PEN_MS),
  parameter int unsigned PWR_CYC  = `AISU_MS2CYC(`AISU_PWR_MS)
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Configuration pins
  input  wire logic                  eight_ch_strap,
  input  wire logic                  elevated_pin,
  input  wire logic                  bcd_pin,
  // Converter front end, same clock
  output logic                       conv_req,
  output aisu_pkg::aisu_chan_t       conv_chan,
  input  wire logic                  conv_done,
  input  wire logic [11:0]           conv_data,
  input  wire logic                  conv_under,
  input  wire logic                  conv_over,
  input  wire logic                  conv_low_band,
  // Diagnostics, same clock
  input  wire logic                  diag_fail,
  // Controller side
  output aisu_pkg::aisu_word_t       chan_value [`AISU_NCH_MAX],
  output logic                       update_pulse,
  output logic                       over_range_led,
  output logic                       powerup_busy
);
  import aisu_pkg::*;

  // ==================================================
  // Pin synchronisers
  logic [1:0] eight_sync;
  logic [1:0] elev_sync;
  logic [1:0] bcd_sync;
  always_ff @(posedge clk) begin
    eight_sync <= {eight_sync[0], eight_ch_strap};
    elev_sync  <= {elev_sync[0], elevated_pin};
    bcd_sync   <= {bcd_sync[0], bcd_pin};
  end

  // ==================================================
  // State
  aisu_state_e state;
  aisu_state_e next_state;
  aisu_chan_t  chan;
  aisu_word_t  shadow [`AISU_NCH_MAX];
  logic [7:0]  oor;
  logic [7:0]  low_band;
  logic [31:0] tick;
  logic [31:0] pwr_cnt;
  logic        eight_sel;
  logic        fail_seen;

  function automatic logic [3:0] count_ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // ==================================================
  // Formatter
  aisu_fmt_if fif (.clk(clk), .reset(reset));
  aisu_format u_format (.f(fif));
  assign fif.raw      = conv_data;
  assign fif.under    = conv_under;
  assign fif.over     = conv_over;
  assign fif.elevated = elev_sync[1];
  assign fif.bcd      = bcd_sync[1];

  // ==================================================
  // Decode
  logic [31:0] base_cyc;
  logic [31:0] target;
  logic        last_chan;
  logic        pwr_done;
  logic        publish;
  logic        store;
  assign base_cyc  = eight_sel ? 32'(INT8_CYC) : 32'(INT4_CYC);
  // Only true range violations cost time; the low band does not
  assign target    = base_cyc + 32'(count_ones(oor)) * 32'(PEN_CYC);
  assign last_chan = chan == (eight_sel ? `AISU_LAST8 : `AISU_LAST4);
  assign pwr_done  = pwr_cnt >= 32'(PWR_CYC) - 32'd1;
  // Publish only after every channel and the interval have both finished
  assign publish   = state == AISU_HOLD && tick >= target - 32'd1;
  assign store     = state == AISU_WAIT && conv_done;
  assign conv_req  = state == AISU_REQ;
  assign conv_chan = chan;
  assign powerup_busy = state == AISU_PWR;
  assign update_pulse = publish;

  always_comb begin
    next_state = state;
    case (state)
      AISU_PWR:  if (pwr_done) next_state = AISU_REQ;
      AISU_REQ:  next_state = AISU_WAIT;
      AISU_WAIT: if (conv_done) next_state = last_chan ? AISU_HOLD : AISU_REQ;
      AISU_HOLD: if (publish) next_state = AISU_REQ;
      default:   next_state = AISU_PWR;
    endcase
  end

  // ==================================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state   <= AISU_PWR;
      chan    <= `AISU_FIRST_CH;
      tick    <= 32'h0000_0000;
      pwr_cnt <= 32'h0000_0000;
    end else begin
      state   <= next_state;
      pwr_cnt <= powerup_busy ? pwr_cnt + 32'd1 : pwr_cnt;
      tick    <= (powerup_busy || publish) ? 32'h0000_0000 : tick + 32'd1;
      if (publish) begin
        chan <= `AISU_FIRST_CH;
      end else if (store && !last_chan) begin
        chan <= chan + 3'h1;
      end
    end
  end

  // Strap is caught while powering up, after reset has released
  always_ff @(posedge clk) begin
    if (reset) begin
      eight_sel <= 1'b0;
    end else if (powerup_busy) begin
      eight_sel <= eight_sync[1];
    end
  end

  // ==================================================
  // Channel results
  always_ff @(posedge clk) begin
    if (reset) begin
      oor      <= 8'h00;
      low_band <= 8'h00;
      over_range_led <= 1'b0;
    end else begin
      if (store) begin
        oor[chan]      <= conv_under | conv_over;
        low_band[chan] <= conv_low_band;
      end
      over_range_led <= |oor | |low_band;
    end
  end

  always_ff @(posedge clk) begin
    if (store) begin
      shadow[chan] <= fif.value;
    end
  end

  // A failure taints the scan in progress; the set wins over the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      fail_seen <= 1'b0;
    end else begin
      fail_seen <= diag_fail | (fail_seen & ~publish);
    end
  end

  // ==================================================
  // Controller registers, zero until a clean scan completes
  always_ff @(posedge clk) begin
    for (int i = 0; i < `AISU_NCH_MAX; i++) begin
      if (reset || diag_fail) begin
        chan_value[i] <= `AISU_ZERO;
      end else if (publish) begin
        chan_value[i] <= (fail_seen || (!eight_sel && i >= `AISU_HI_CH)) ? `AISU_ZERO : shadow[i];
      end
    end
  end

  // ==================================================
  // Checks
  logic any_value;
  logic hi_value;
  always_comb begin
    any_value = 1'b0;
    hi_value  = 1'b0;
    for (int i = 0; i < `AISU_NCH_MAX; i++) begin
      any_value = any_value | (|chan_value[i]);
      if (i >= `AISU_HI_CH) begin
        hi_value = hi_value | (|chan_value[i]);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  powerup_zero_a: assert property (powerup_busy |-> !any_value)
    else $error("value nonzero during power-up");
  diag_zero_a: assert property (diag_fail |=> !any_value)
    else $error("value nonzero after diagnostic failure");
  recovery_zero_a: assert property (publish && fail_seen |=> !any_value)
    else $error("tainted scan published data");
  interval_len_a: assert property (publish && $past(state) == AISU_HOLD |-> tick == target - 32'd1)
    else $error("update interval length wrong");
  // Built-in count keeps this independent of the counting function it guards
  penalty_a: assert property (target == base_cyc + 32'($countones(oor)) * 32'(PEN_CYC))
    else $error("interval penalty wrong");
  low_band_led_a: assert property (store && conv_low_band |=> ##1 over_range_led)
    else $error("low band did not light indicator");
  four_ch_a: assert property (!eight_sel && !powerup_busy |-> !hi_value)
    else $error("upper registers used on four channels");
  scan_order_a: assert property (conv_req |=> !conv_req && state == AISU_WAIT)
    else $error("request not followed by wait");

  scan_cover_c:  cover property (publish && !fail_seen);
  penalty_cover_c: cover property (publish && |oor);
  fail_cover_c:  cover property (diag_fail ##[1:200] publish);
endmodule
`default_nettype wire

// ---- testbench/aisu_conv_model.sv ----
// Converter front end model answering the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module aisu_conv_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Bench controls
  input  wire logic        slow,
  input  wire logic [11:0] raw,
  input  wire logic [7:0]  under_mask,
  input  wire logic        over,
  input  wire logic        low,
  // Scan side
  input  wire logic        conv_req,
  input  wire logic [2:0]  conv_chan,
  output logic             conv_done,
  output logic [11:0]      conv_data,
  output logic             conv_under,
  output logic             conv_over,
  output logic             conv_low_band
);
  logic [2:0] cnt;
  // ==================================================
  // Result lines
  // Outside a result the lines show inverted values, so a stale sample never matches
  assign conv_data     = conv_done ? raw : ~raw;
  assign conv_under    = conv_done ? under_mask[conv_chan] : ~under_mask[conv_chan];
  assign conv_over     = conv_done ? over : ~over;
  assign conv_low_band = conv_done ? low : ~low;
  // ==================================================
  // Answer timing
  // A slow answer keeps the request waiting three extra cycles
  always_ff @(posedge clk) begin
    conv_done <= 1'b0;
    if (reset) begin
      cnt <= 3'h0;
    end else if (conv_req) begin
      cnt <= slow ? 3'h4 : 3'h1;
    end else if (cnt != 3'h0) begin
      cnt       <= cnt - 3'h1;
      conv_done <= (cnt == 3'h1);
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_analog_input_scan_update.sv ----
// Self-checking bench of the analog input scan and update block
`timescale 1ns/1ps
`default_nettype none
`include "aisu_defs.svh"
module tb_analog_input_scan_update;
  import aisu_pkg::*;
  typedef struct packed {
    logic [11:0] raw;
    logic        und;
    logic        ovr;
    logic        elv;
    logic        bcd;
    aisu_word_t  exp;
  } aisu_row_s;
  localparam aisu_row_s ROWS [9] = '{
    '{12'h123, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0123}, '{12'hfff, 1'b0, 1'b0, 1'b1, 1'b0, 16'h1fff},
    '{12'h000, 1'b0, 1'b0, 1'b1, 1'b0, 16'h1000}, '{12'h555, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{12'h555, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0fff}, '{12'h555, 1'b0, 1'b1, 1'b0, 1'b0, 16'h1000},
    '{12'h555, 1'b0, 1'b1, 1'b1, 1'b0, 16'h2000}, '{12'hfff, 1'b0, 1'b0, 1'b0, 1'b1, 16'h4095},
    '{12'h555, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0000}};
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        strap = 1'b0;
  logic        elev = 1'b0;
  logic        bcd = 1'b0;
  logic        diag = 1'b0;
  logic        slow = 1'b0;
  logic [11:0] raw = 12'h123;
  logic [7:0]  umask = 8'h00;
  logic        over = 1'b0;
  logic        low = 1'b0;
  logic        req, done, cu, co, cl, pulse, led, busy;
  logic [2:0]  chan;
  logic [11:0] cdata;
  aisu_word_t  val [`AISU_NCH_MAX];
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;
  int          n;
  // ==================================================
  // Design and converter model
  aisu_scan #(.INT4_CYC(40), .INT8_CYC(60), .PEN_CYC(20), .PWR_CYC(10)) dut_u (
    .clk(clk), .reset(reset), .eight_ch_strap(strap), .elevated_pin(elev), .bcd_pin(bcd),
    .conv_req(req), .conv_chan(chan), .conv_done(done), .conv_data(cdata), .conv_under(cu),
    .conv_over(co), .conv_low_band(cl), .diag_fail(diag), .chan_value(val),
    .update_pulse(pulse), .over_range_led(led), .powerup_busy(busy));
  aisu_conv_model conv_u (
    .clk(clk), .reset(reset), .slow(slow), .raw(raw), .under_mask(umask), .over(over),
    .low(low), .conv_req(req), .conv_chan(chan), .conv_done(done), .conv_data(cdata),
    .conv_under(cu), .conv_over(co), .conv_low_band(cl));
  always #20 clk = ~clk;
  // ==================================================
  // Tasks
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic cmp_word(input aisu_word_t got, input aisu_word_t exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Four-state compare so an unknown level never passes as a match
  task automatic cmp_cnt(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pulse wait is bounded so a silent design cannot hang the run
  task automatic wait_pulse();
    n = 0;
    step();
    while (pulse !== 1'b1 && n < 2000) begin
      step();
      n++;
    end
    if (n >= 2000) fails++;
  endtask
  // Interval is counted from one publish to the next, after a settling interval
  task automatic measure(input int exp);
    wait_pulse();
    wait_pulse();
    n = 1;
    step();
    while (pulse !== 1'b1 && n < 500) begin
      step();
      n++;
    end
    cmp_cnt(n, exp);
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ==================================================
  // Main sequence
  initial begin
    repeat (3) step();
    cmp_word(val[0], 16'h0000);
    cmp_cnt(32'(busy), 32'h1);
    cmp_cnt(32'(led), 32'h0);
    reset = 1'b0;
    foreach (ROWS[i]) begin
      raw = ROWS[i].raw;
      umask = {8{ROWS[i].und}};
      over = ROWS[i].ovr;
      elev = ROWS[i].elv;
      bcd = ROWS[i].bcd;
      wait_pulse();
      wait_pulse();
      step();
      cmp_word(val[2], ROWS[i].exp);
    end
    {raw, umask, over, elev, bcd, slow} = {12'h123, 8'h00, 4'h1};
    measure(40);
    cmp_word(val[5], 16'h0000);
    slow = 1'b0;
    umask = 8'h01;
    measure(60);
    umask = 8'h00;
    low = 1'b1;
    measure(40);
    cmp_cnt(32'(led), 32'h1);
    low = 1'b0;
    wait_pulse();
    step();
    diag = 1'b1;
    step();
    diag = 1'b0;
    step();
    cmp_word(val[1], 16'h0000);
    wait_pulse();
    step();
    cmp_word(val[1], 16'h0000);
    wait_pulse();
    step();
    cmp_word(val[1], 16'h0123);
    cmp_cnt(32'(led), 32'h0);
    cmp_cnt(32'(busy), 32'h0);
    reset = 1'b1;
    strap = 1'b1;
    repeat (3) step();
    reset = 1'b0;
    step();
    cmp_word(val[7], 16'h0000);
    cmp_cnt(32'(busy), 32'h1);
    measure(60);
    cmp_word(val[7], 16'h0123);
    umask = 8'h81;
    measure(100);
    tally_and_finish();
  end
endmodule
`default_nettype wire
